// File: hw/pbs_target.sv
// pbs_target: the device end, a bus target with a word-wide user port
// assumes: bus reset comes from the interface and the clock comes in on its own port
`timescale 1ns/1ps
`default_nettype none
module pbs_target #(
  parameter int unsigned BASE_BITS = 16,
  parameter logic [31:0] BASE_ADDR = 32'h0001_0000
) (
  // clock and enable
  input wire logic sys_clk_i,
  input wire logic clk_en_i,
  // bus
  pbs_bus_if.target bus,
  // core clock choice and reset status
  input wire logic core_from_bus_clk_i,
  output logic fast_scsi_ok_o,
  output logic in_reset_o,
  // user port
  output logic [31:0] usr_addr_o,
  output logic usr_cfg_o,
  output logic usr_wr_o,
  output logic [31:0] usr_wdata_o,
  output logic [3:0] usr_be_o,
  input wire logic [31:0] usr_rdata_i,
  input wire logic usr_stop_i
);

  // --------------------------------------------------------------------------
  // types and state
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    T_IDLE = 3'b000,
    T_WAIT = 3'b001,
    T_DATA = 3'b010,
    T_STOP = 3'b011,
    T_TURN = 3'b100
  } pbs_tstate_e;

  pbs_tstate_e state;
  pbs_tstate_e next_state;
  logic rst_meta;
  logic rst_sync;
  logic frame_prev_n;
  logic [31:0] addr;
  logic write;
  logic cfg;
  logic [31:0] ad_q;
  logic par_q;
  logic par_oe_n;
  logic start;
  logic hit;
  logic done;
  logic claimed;

  function automatic logic mem_hit(input logic [31:0] a);
    mem_hit = (a[31:BASE_BITS] == BASE_ADDR[31:BASE_BITS]);
  endfunction

  // --------------------------------------------------------------------------
  // reset synchroniser
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (clk_en_i) begin
      rst_meta <= bus.rst_n;
      rst_sync <= rst_meta;
    end
  end

  // --------------------------------------------------------------------------
  // decode
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (clk_en_i) begin
      if (!rst_sync) begin
        frame_prev_n <= 1'b1;
      end else begin
        frame_prev_n <= bus.frame_n;
      end
    end
  end

  // first clock with frame low is the address phase
  assign start = !bus.frame_n && frame_prev_n && bus.irdy_n;
  always_comb begin
    hit = 1'b0;
    case (bus.cbe_n)
      pbs_pkg::CMD_MEM_RD: hit = mem_hit(bus.ad);
      pbs_pkg::CMD_MEM_WR: hit = mem_hit(bus.ad);
      pbs_pkg::CMD_CFG_RD: hit = bus.idsel;
      pbs_pkg::CMD_CFG_WR: hit = bus.idsel;
      default: hit = 1'b0;
    endcase
  end

  // data phase ends when both ready lines are low
  assign done = (state == T_DATA) && !bus.irdy_n && !usr_stop_i;

  // --------------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      T_IDLE: begin
        if (start && hit) begin
          next_state = T_WAIT;
        end
      end
      T_WAIT: begin
        next_state = T_DATA;
      end
      T_DATA: begin
        if (usr_stop_i) begin
          next_state = T_STOP;
        end else if (done && bus.frame_n) begin
          next_state = T_TURN;
        end else if (done && !write) begin
          next_state = T_WAIT;
        end
      end
      T_STOP: begin
        if (bus.frame_n) begin
          next_state = T_TURN;
        end
      end
      T_TURN: begin
        next_state = T_IDLE;
      end
      default: begin
        next_state = T_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (clk_en_i) begin
      if (!rst_sync) begin
        state <= T_IDLE;
      end else begin
        state <= next_state;
      end
    end
  end

  // --------------------------------------------------------------------------
  // address and command capture
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (clk_en_i) begin
      if (!rst_sync) begin
        addr <= pbs_pkg::AD_RST;
        write <= 1'b0;
        cfg <= 1'b0;
      end else if (state == T_IDLE && start && hit) begin
        addr <= bus.ad;
        write <= bus.cbe_n[pbs_pkg::CMD_WR_BIT];
        cfg <= bus.cbe_n[pbs_pkg::CMD_CFG_BIT];
      end else if (done && !usr_stop_i) begin
        addr <= addr + pbs_pkg::ADDR_STEP;
      end
    end
  end

  // --------------------------------------------------------------------------
  // write data to the user side
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (clk_en_i) begin
      if (!rst_sync) begin
        usr_wr_o <= 1'b0;
        usr_wdata_o <= pbs_pkg::AD_RST;
        usr_be_o <= ~pbs_pkg::BE_RST;
      end else begin
        usr_wr_o <= done && write && !usr_stop_i;
        if (done && write) begin
          usr_wdata_o <= bus.ad;
          usr_be_o <= ~bus.cbe_n;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // read data and parity
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (clk_en_i) begin
      if (!rst_sync) begin
        ad_q <= pbs_pkg::AD_RST;
      end else if (state == T_WAIT) begin
        ad_q <= usr_rdata_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (clk_en_i) begin
      if (!rst_sync) begin
        par_q <= 1'b0;
        par_oe_n <= 1'b1;
      end else begin
        par_q <= pbs_pkg::even_par(ad_q, bus.cbe_n);
        par_oe_n <= bus.t_ad_oe_n;
      end
    end
  end

  // --------------------------------------------------------------------------
  // status outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (clk_en_i) begin
      if (!rst_sync) begin
        fast_scsi_ok_o <= 1'b1;
      end else begin
        fast_scsi_ok_o <= !core_from_bus_clk_i;
      end
    end
  end

  assign in_reset_o = !rst_sync;
  assign usr_addr_o = addr;
  assign usr_cfg_o = cfg;

  // --------------------------------------------------------------------------
  // pin drivers
  // --------------------------------------------------------------------------
  assign claimed = (state == T_WAIT) || (state == T_DATA) || (state == T_STOP);
  assign bus.t_devsel_n = !claimed;
  assign bus.t_trdy_n = !(state == T_DATA && !usr_stop_i);
  assign bus.t_stop_n = !(state == T_STOP || (state == T_DATA && usr_stop_i));
  assign bus.t_ctl_oe_n = !rst_sync || !(claimed || state == T_TURN);
  assign bus.t_ad = ad_q;
  assign bus.t_ad_oe_n = !rst_sync || !(state == T_DATA && !write);
  assign bus.t_par = par_q;
  assign bus.t_par_oe_n = !rst_sync || par_oe_n;

endmodule
`default_nettype wire

// File: hw/pbs_pkg.sv
// pbs_pkg: shared constants for the expansion bus target and initiator
// assumes: one bus clock shared by both ends, all bus pins sampled on its rising edge
package pbs_pkg;

  // --------------------------------------------------------------------------
  // bus commands
  // --------------------------------------------------------------------------
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'ha;
  localparam logic [3:0] CMD_CFG_WR = 4'hb;
  localparam int unsigned CMD_WR_BIT = 0;
  localparam int unsigned CMD_CFG_BIT = 3;

  // --------------------------------------------------------------------------
  // layout, steps and reset values
  // --------------------------------------------------------------------------
  localparam int unsigned AD_W = 32;
  localparam int unsigned BE_W = 4;
  localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
  localparam logic [31:0] AD_RST = 32'h0000_0000;
  localparam logic [3:0] BE_RST = 4'hf;
  localparam logic [3:0] BE_ALL_OFF = 4'hf;

  // --------------------------------------------------------------------------
  // cycle counts
  // --------------------------------------------------------------------------
  localparam logic [2:0] DEVSEL_WAIT_CYC = 3'h5;
  localparam logic [2:0] WAIT_CNT_RST = 3'h0;

  // even parity over data and enables
  function automatic logic even_par(input logic [31:0] ad, input logic [3:0] cbe);
    even_par = ^{ad, cbe};
  endfunction

endpackage

// File: hw/pbs_bus_if.sv
// pbs_bus_if: the shared bus wires between initiator and target
// assumes: released wires float high through pull-ups, modelled here as ones
`timescale 1ns/1ps
`default_nettype none
interface pbs_bus_if;

  // --------------------------------------------------------------------------
  // per-end drivers
  // --------------------------------------------------------------------------
  logic [31:0] m_ad;
  logic m_ad_oe_n;
  logic [3:0] m_cbe_n;
  logic m_par;
  logic m_par_oe_n;
  logic m_frame_n;
  logic m_irdy_n;
  logic m_ctl_oe_n;
  logic m_idsel;
  logic m_rst_n;
  logic [31:0] t_ad;
  logic t_ad_oe_n;
  logic t_par;
  logic t_par_oe_n;
  logic t_devsel_n;
  logic t_trdy_n;
  logic t_stop_n;
  logic t_ctl_oe_n;

  // --------------------------------------------------------------------------
  // resolved wires
  // --------------------------------------------------------------------------
  logic [31:0] ad;
  logic [3:0] cbe_n;
  logic par;
  logic frame_n;
  logic irdy_n;
  logic devsel_n;
  logic trdy_n;
  logic stop_n;
  logic idsel;
  logic rst_n;

  assign ad = !m_ad_oe_n ? m_ad : (!t_ad_oe_n ? t_ad : '1);
  assign cbe_n = !m_ctl_oe_n ? m_cbe_n : '1;
  assign par = !m_par_oe_n ? m_par : (!t_par_oe_n ? t_par : 1'b1);
  assign frame_n = m_ctl_oe_n | m_frame_n;
  assign irdy_n = m_ctl_oe_n | m_irdy_n;
  assign devsel_n = t_ctl_oe_n | t_devsel_n;
  assign trdy_n = t_ctl_oe_n | t_trdy_n;
  assign stop_n = t_ctl_oe_n | t_stop_n;
  assign idsel = m_idsel;
  assign rst_n = m_rst_n;

  modport initiator (
    output m_ad, m_ad_oe_n, m_cbe_n, m_par, m_par_oe_n, m_frame_n, m_irdy_n,
    output m_ctl_oe_n, m_idsel, m_rst_n,
    input ad, frame_n, irdy_n, devsel_n, trdy_n, stop_n
  );

  modport target (
    output t_ad, t_ad_oe_n, t_par, t_par_oe_n, t_devsel_n, t_trdy_n, t_stop_n, t_ctl_oe_n,
    input ad, cbe_n, frame_n, irdy_n, idsel, rst_n
  );

endinterface
`default_nettype wire

// File: hw/pbs_initiator.sv
// pbs_initiator: the far end, a bus initiator driven by a request port
// assumes: single master on the bus, it also drives the bus reset line
`timescale 1ns/1ps
`default_nettype none
module pbs_initiator #(
  parameter int unsigned CNT_W = 8
) (
  // clock, reset and enable
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  // bus
  pbs_bus_if.initiator bus,
  // request port
  input wire logic req_i,
  input wire logic req_write_i,
  input wire logic req_cfg_i,
  input wire logic [31:0] req_addr_i,
  input wire logic [3:0] req_be_i,
  input wire logic [CNT_W-1:0] req_count_i,
  input wire logic [31:0] wdata_i,
  // answer port
  output logic busy_o,
  output logic wr_take_o,
  output logic [31:0] rd_data_o,
  output logic rd_valid_o,
  output logic done_o,
  output logic abort_o,
  output logic stopped_o
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_ADDR = 2'b01,
    M_DATA = 2'b10,
    M_TURN = 2'b11
  } pbs_mstate_e;

  pbs_mstate_e state;
  logic [31:0] ad_q;
  logic [3:0] cbe_q;
  logic [3:0] be;
  logic frame_on;
  logic irdy_on;
  logic ad_oe_n;
  logic ctl_oe_n;
  logic idsel_q;
  logic par_q;
  logic par_oe_n;
  logic write;
  logic [CNT_W-1:0] remain;
  logic [2:0] wait_cnt;
  logic complete;

  assign complete = irdy_on && !bus.trdy_n;

  // --------------------------------------------------------------------------
  // sequencer and drivers
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (clk_en_i) begin
      wr_take_o <= 1'b0;
      rd_valid_o <= 1'b0;
      done_o <= 1'b0;
      abort_o <= 1'b0;
      stopped_o <= 1'b0;
      if (!resetn_i) begin
        state <= M_IDLE;
        ad_q <= pbs_pkg::AD_RST;
        cbe_q <= pbs_pkg::BE_RST;
        be <= pbs_pkg::BE_RST;
        frame_on <= 1'b0;
        irdy_on <= 1'b0;
        ad_oe_n <= 1'b1;
        ctl_oe_n <= 1'b1;
        idsel_q <= 1'b0;
        write <= 1'b0;
        remain <= '0;
        wait_cnt <= pbs_pkg::WAIT_CNT_RST;
        rd_data_o <= pbs_pkg::AD_RST;
      end else begin
        case (state)
          M_IDLE: begin
            if (req_i && bus.frame_n && bus.irdy_n) begin
              state <= M_ADDR;
              ad_q <= req_addr_i;
              cbe_q <= req_cfg_i ? (req_write_i ? pbs_pkg::CMD_CFG_WR : pbs_pkg::CMD_CFG_RD)
                                 : (req_write_i ? pbs_pkg::CMD_MEM_WR : pbs_pkg::CMD_MEM_RD);
              be <= ~req_be_i;
              frame_on <= 1'b1;
              ad_oe_n <= 1'b0;
              ctl_oe_n <= 1'b0;
              idsel_q <= req_cfg_i;
              write <= req_write_i;
              remain <= req_count_i;
            end
          end
          M_ADDR: begin
            state <= M_DATA;
            cbe_q <= be;
            irdy_on <= 1'b1;
            idsel_q <= 1'b0;
            wait_cnt <= pbs_pkg::WAIT_CNT_RST;
            frame_on <= (remain > 1);
            if (write) begin
              ad_q <= wdata_i;
              wr_take_o <= 1'b1;
            end else begin
              ad_oe_n <= 1'b1;
            end
          end
          M_DATA: begin
            if (bus.devsel_n && wait_cnt != pbs_pkg::DEVSEL_WAIT_CYC) begin
              wait_cnt <= wait_cnt + 3'h1;
            end
            if (bus.devsel_n && wait_cnt == pbs_pkg::DEVSEL_WAIT_CYC) begin
              state <= M_TURN;
              frame_on <= 1'b0;
              irdy_on <= 1'b0;
              abort_o <= 1'b1;
            end else if (complete) begin
              remain <= remain - 1'b1;
              if (!write) begin
                rd_data_o <= bus.ad;
                rd_valid_o <= 1'b1;
              end
              if (!frame_on) begin
                state <= M_TURN;
                irdy_on <= 1'b0;
                done_o <= 1'b1;
              end else begin
                frame_on <= (remain > 2);
                if (write) begin
                  ad_q <= wdata_i;
                  wr_take_o <= 1'b1;
                end
              end
            end else if (!bus.stop_n) begin
              if (frame_on) begin
                frame_on <= 1'b0;
              end else begin
                state <= M_TURN;
                irdy_on <= 1'b0;
                stopped_o <= 1'b1;
              end
            end
          end
          M_TURN: begin
            state <= M_IDLE;
            ad_oe_n <= 1'b1;
            ctl_oe_n <= 1'b1;
            cbe_q <= pbs_pkg::BE_RST;
          end
          default: begin
            state <= M_IDLE;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // parity, one clock behind the data it covers
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (clk_en_i) begin
      if (!resetn_i) begin
        par_q <= 1'b0;
        par_oe_n <= 1'b1;
      end else begin
        par_q <= pbs_pkg::even_par(ad_q, cbe_q);
        par_oe_n <= ad_oe_n;
      end
    end
  end

  assign busy_o = (state != M_IDLE);
  assign bus.m_ad = ad_q;
  assign bus.m_ad_oe_n = ad_oe_n;
  assign bus.m_cbe_n = cbe_q;
  assign bus.m_par = par_q;
  assign bus.m_par_oe_n = par_oe_n;
  assign bus.m_frame_n = !frame_on;
  assign bus.m_irdy_n = !irdy_on;
  assign bus.m_ctl_oe_n = ctl_oe_n;
  assign bus.m_idsel = idsel_q;
  assign bus.m_rst_n = resetn_i;

endmodule
`default_nettype wire

// File: test/pbs_bus_assertions.sv
// pbs_bus_assertions: protocol checks on the shared bus wires
// assumes: placed beside the bus interface, one clock for both ends
`timescale 1ns/1ps
`default_nettype none
module pbs_bus_assertions #(
  parameter int unsigned BASE_BITS = 16,
  parameter logic [31:0] BASE_ADDR = 32'h0001_0000
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n,
  // resolved bus
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe_n,
  input wire logic par,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic devsel_n,
  input wire logic trdy_n,
  input wire logic stop_n,
  input wire logic idsel,
  // drive enables
  input wire logic m_ad_oe_n,
  input wire logic t_ad_oe_n,
  input wire logic t_ctl_oe_n
);
  // --------------------------------------------------------------------------
  // phases
  // --------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n);
  sequence s_addr;
    $fell(frame_n);
  endsequence
  sequence s_done;
    !irdy_n && !trdy_n;
  endsequence
  sequence s_turn;
    !t_ctl_oe_n ##1 t_ctl_oe_n;
  endsequence

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  AST_RESET_FLOAT: assert property ($rose(rst_n) && !$past(rst_n, 2) |-> t_ctl_oe_n && t_ad_oe_n)
    else $error("target drives while in reset");
  AST_CMD_CODE: assert property (s_addr |-> cbe_n inside {4'h6, 4'h7, 4'ha, 4'hb})
    else $error("bad command in address phase");
  AST_ADDR_PAR: assert property (s_addr |=> par == ^{$past(ad), $past(cbe_n)})
    else $error("address parity wrong");
  AST_DATA_PAR: assert property (s_done |=> par == ^{$past(ad), $past(cbe_n)})
    else $error("data parity wrong");
  AST_MEM_CLAIM: assert property ($fell(frame_n) && cbe_n[3:1] == 3'b011
    && ad[31:BASE_BITS] == BASE_ADDR[31:BASE_BITS] |=> !devsel_n)
    else $error("memory hit not claimed");
  AST_MEM_MISS: assert property ($fell(frame_n) && cbe_n[3:1] == 3'b011
    && ad[31:BASE_BITS] != BASE_ADDR[31:BASE_BITS] |=> devsel_n [*6])
    else $error("memory miss claimed");
  AST_CFG_CLAIM: assert property ($fell(frame_n) && cbe_n[3:1] == 3'b101 && idsel |=> !devsel_n)
    else $error("config access not claimed");
  AST_WAIT_HOLD: assert property (!irdy_n && trdy_n && stop_n && !devsel_n |=> !irdy_n)
    else $error("initiator ready dropped in wait");
  AST_TRDY_STOP: assert property (trdy_n || stop_n)
    else $error("target ready and stop together");
  AST_LAST_PHASE: assert property ($rose(frame_n) && !devsel_n |-> !irdy_n)
    else $error("frame released outside last phase");
  AST_TURN: assert property ($rose(devsel_n) |-> s_turn)
    else $error("target released without turn cycle");
  AST_ONE_OWNER: assert property (m_ad_oe_n || t_ad_oe_n)
    else $error("two drivers on address data");
endmodule
`default_nettype wire

// File: test/tb_pci_bus_signal_protocol.sv
// tb_pci_bus_signal_protocol: initiator and target joined, directed transfers
// assumes: one clock for both ends; target reset arrives through the bus
`timescale 1ns/1ps
`default_nettype none
module tb_pci_bus_signal_protocol;
  // --------------------------------------------------------------------------
  // stimulus and observation
  // --------------------------------------------------------------------------
  localparam logic [31:0] BASE = 32'h0001_0000;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic core_clk = 1'b0;
  logic usr_stop = 1'b0;
  logic req_i = 1'b0;
  logic req_write = 1'b0;
  logic req_cfg = 1'b0;
  logic [31:0] req_addr = 32'h0;
  logic [3:0] req_be = 4'hf;
  logic [7:0] req_count = 8'h01;
  logic [31:0] wdata = 32'h0;
  logic [31:0] usr_rdata, usr_addr, usr_wdata, rd_data;
  logic [3:0] usr_be;
  logic fast_ok, in_reset, usr_cfg, usr_wr, busy, rd_valid, done, abort, stopped;
  logic wr_take;
  int ntake = 0;
  logic [31:0] rdq[$];
  logic [31:0] a_ad, d_ad, w_data;
  logic [3:0] a_cbe, d_cbe, w_be;
  logic prev_frame_n = 1'b1;
  logic [1:0] ending;
  int nwr = 0;
  int mismatches = 0;
  int compares = 0;

  always #4 sys_clk_i = ~sys_clk_i;
  assign usr_rdata = usr_addr ^ 32'h5a5a_c3c3;

  pbs_bus_if bus_if ();
  pbs_target #(.BASE_BITS(16), .BASE_ADDR(BASE)) i_pbs_target (.sys_clk_i(sys_clk_i),
    .clk_en_i(1'b1), .bus(bus_if.target), .core_from_bus_clk_i(core_clk),
    .fast_scsi_ok_o(fast_ok), .in_reset_o(in_reset), .usr_addr_o(usr_addr),
    .usr_cfg_o(usr_cfg), .usr_wr_o(usr_wr), .usr_wdata_o(usr_wdata), .usr_be_o(usr_be),
    .usr_rdata_i(usr_rdata), .usr_stop_i(usr_stop));
  pbs_initiator #(.CNT_W(8)) i_pbs_initiator (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .clk_en_i(1'b1), .bus(bus_if.initiator), .req_i(req_i), .req_write_i(req_write),
    .req_cfg_i(req_cfg), .req_addr_i(req_addr), .req_be_i(req_be), .req_count_i(req_count),
    .wdata_i(wdata), .busy_o(busy), .wr_take_o(wr_take), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .done_o(done), .abort_o(abort), .stopped_o(stopped));
  pbs_bus_assertions #(.BASE_BITS(16), .BASE_ADDR(BASE)) i_pbs_bus_assertions (
    .sys_clk_i(sys_clk_i), .rst_n(bus_if.rst_n), .ad(bus_if.ad), .cbe_n(bus_if.cbe_n),
    .par(bus_if.par), .frame_n(bus_if.frame_n), .irdy_n(bus_if.irdy_n),
    .devsel_n(bus_if.devsel_n), .trdy_n(bus_if.trdy_n), .stop_n(bus_if.stop_n),
    .idsel(bus_if.idsel), .m_ad_oe_n(bus_if.m_ad_oe_n), .t_ad_oe_n(bus_if.t_ad_oe_n),
    .t_ctl_oe_n(bus_if.t_ctl_oe_n));

  // wire and user side capture
  always @(posedge sys_clk_i) begin
    prev_frame_n <= bus_if.frame_n;
    if (prev_frame_n && !bus_if.frame_n) begin
      a_ad <= bus_if.ad;
      a_cbe <= bus_if.cbe_n;
    end
    if (!bus_if.irdy_n && !bus_if.trdy_n) begin
      d_ad <= bus_if.ad;
      d_cbe <= bus_if.cbe_n;
    end
    if (rd_valid === 1'b1) begin
      rdq.push_back(rd_data);
    end
    if (wr_take === 1'b1) begin
      ntake <= ntake + 1;
    end
    if (usr_wr === 1'b1) begin
      nwr <= nwr + 1;
      w_data <= usr_wdata;
      w_be <= usr_be;
    end
  end

  // --------------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic xfer(input logic wr, input logic cfg, input logic [31:0] addr,
                      input logic [3:0] be, input logic [7:0] cnt, input logic [31:0] wd);
    int n;
    req_write = wr;
    req_cfg = cfg;
    req_addr = addr;
    req_be = be;
    req_count = cnt;
    wdata = wd;
    req_i = 1'b1;
    n = 0;
    ending = 2'd0;
    rdq.delete();
    while (busy !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    req_i = 1'b0;
    while (ending == 2'd0 && n < 200) begin
      if (done === 1'b1) ending = 2'd1;
      else if (abort === 1'b1) ending = 2'd2;
      else if (stopped === 1'b1) ending = 2'd3;
      else cyc(1);
      n++;
    end
    if (ending == 2'd0) begin
      mismatches++;
      tally_and_finish();
    end
    cyc(3);
  endtask

  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  task automatic reset_scenario();
    cyc(16);
    check("in_reset", in_reset, 1'b1);
    check("tgt_ctl_oe_n", bus_if.t_ctl_oe_n, 1'b1);
    check("tgt_ad_oe_n", bus_if.t_ad_oe_n, 1'b1);
    resetn_i = 1'b1;
    cyc(1);
    check("in_reset_sync", in_reset, 1'b1);
    cyc(1);
    check("in_reset_done", in_reset, 1'b0);
    core_clk = 1'b1;
    cyc(2);
    check("fast_ok_bus_clk", fast_ok, 1'b0);
    core_clk = 1'b0;
    cyc(2);
    check("fast_ok_own_clk", fast_ok, 1'b1);
  endtask

  task automatic write_scenario();
    xfer(1'b1, 1'b0, BASE + 32'h20, 4'h5, 8'h01, 32'h1234_abcd);
    check("wr_end", ending, 2'd1);
    check("wr_count", nwr, 1);
    check("wr_addr_phase", a_ad, BASE + 32'h20);
    check("wr_cmd", a_cbe, pbs_pkg::CMD_MEM_WR);
    check("wr_bus_data", d_ad, 32'h1234_abcd);
    check("wr_bus_be_n", d_cbe, 4'ha);
    check("wr_usr_data", w_data, 32'h1234_abcd);
    check("wr_usr_be", w_be, 4'h5);
    check("wr_takes", ntake, 1);
    check("wr_cfg_flag", usr_cfg, 1'b0);
  endtask

  task automatic read_scenario();
    xfer(1'b0, 1'b0, BASE + 32'h8, 4'hf, 8'h02, 32'h0);
    check("rd_end", ending, 2'd1);
    check("rd_cmd", a_cbe, pbs_pkg::CMD_MEM_RD);
    check("rd_words", rdq.size(), 2);
    check("rd_word0", rdq[0], (BASE + 32'h8) ^ 32'h5a5a_c3c3);
    check("rd_word1", rdq[1], (BASE + 32'hc) ^ 32'h5a5a_c3c3);
  endtask

  task automatic config_scenario();
    xfer(1'b0, 1'b1, 32'h0000_0040, 4'hf, 8'h01, 32'h0);
    check("cfg_rd_end", ending, 2'd1);
    check("cfg_rd_cmd", a_cbe, pbs_pkg::CMD_CFG_RD);
    check("cfg_rd_data", rdq[0], 32'h5a5a_c383);
    xfer(1'b1, 1'b1, 32'h0000_0044, 4'hc, 8'h01, 32'h0bad_cafe);
    check("cfg_wr_end", ending, 2'd1);
    check("cfg_wr_cmd", a_cbe, pbs_pkg::CMD_CFG_WR);
    check("cfg_wr_flag", usr_cfg, 1'b1);
    check("cfg_wr_data", w_data, 32'h0bad_cafe);
  endtask

  task automatic mid_reset_scenario();
    req_write = 1'b0;
    req_cfg = 1'b0;
    req_addr = BASE;
    req_count = 8'h01;
    req_i = 1'b1;
    cyc(1);
    req_i = 1'b0;
    cyc(1);
    check("mid_claim", bus_if.devsel_n, 1'b0);
    resetn_i = 1'b0;
    cyc(2);
    check("mid_busy", busy, 1'b0);
    check("mid_ctl_oe_n", bus_if.t_ctl_oe_n, 1'b1);
    check("mid_ad_oe_n", bus_if.t_ad_oe_n, 1'b1);
    check("mid_in_reset", in_reset, 1'b1);
    cyc(2);
    resetn_i = 1'b1;
    cyc(3);
    check("mid_in_reset_done", in_reset, 1'b0);
    check("mid_devsel_n", bus_if.devsel_n, 1'b1);
  endtask

  task automatic miss_and_stop_scenario();
    xfer(1'b0, 1'b0, 32'h0002_0000, 4'hf, 8'h01, 32'h0);
    check("miss_end", ending, 2'd2);
    usr_stop = 1'b1;
    xfer(1'b1, 1'b0, BASE, 4'hf, 8'h04, 32'h7777_1111);
    usr_stop = 1'b0;
    check("stop_end", ending, 2'd3);
    check("stop_no_write", nwr, 2);
  endtask

  initial begin
    reset_scenario();
    write_scenario();
    read_scenario();
    config_scenario();
    mid_reset_scenario();
    miss_and_stop_scenario();
    tally_and_finish();
  end
endmodule
`default_nettype wire
